/* File: ser_map.svh */
`ifndef SER_MAP_SVH
`define SER_MAP_SVH
// ****************************************
// bit positions
// ****************************************
`define SER_QUES_OVLD 0
`define SER_QUES_TEMP 4
`define SER_QUES_UNLOCK 5
`define SER_QUES_MODOVL 7
`define SER_QUES_CAL 8
`define SER_QUES_EXTREF 9
`define SER_QUES_USED 16'h03B1
`define SER_ESR_OPC 0
`define SER_ESR_QYE 2
`define SER_ESR_DDE 3
`define SER_ESR_EXE 4
`define SER_ESR_CME 5
`define SER_ESR_PON 7
`define SER_ESR_USED 8'hBD
`define SER_STB_ERRQ 2
`define SER_STB_QUES 3
`define SER_STB_MAV 4
`define SER_STB_ESB 5
`define SER_STB_RQS 6
`define SER_STB_USED 8'h3C
// ****************************************
// reset values
// ****************************************
`define SER_ZERO16 16'h0000
`define SER_ZERO8 8'h00
`define SER_PSC_DEFAULT 1'b1
`endif

/* File: ser_pkg.sv */
package ser_pkg;
	// ****************************************
	// command strobes, one per executed command
	// ****************************************
	typedef struct packed {
		logic clear_status;
		logic status_preset;
		logic ques_query;
		logic esr_query;
		logic stb_query;
		logic ques_en_write;
		logic esr_en_write;
		logic sre_write;
		logic psc_write;
		logic opc_cmd;
	} ser_cmd_t;
	typedef struct packed {
		logic query_error;
		logic device_error;
		logic exec_error;
		logic cmd_error;
	} ser_err_t;
	typedef enum logic [1:0] {
		SER_OPC_IDLE,
		SER_OPC_WAIT
	} ser_opc_state_t;
endpackage : ser_pkg

/* File: ser_event_latch.sv */
`timescale 1ns/10ps
module ser_event_latch #(
	parameter int W = 8
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [W-1:0] cond,
	input wire logic [W-1:0] pulse,
	input wire logic [W-1:0] used,
	input wire logic clear,
	output logic [W-1:0] event_q
);
	logic [W-1:0] cond_prev;
	wire logic [W-1:0] rise = (cond & ~cond_prev) | pulse;
	// set beats clear so a same-cycle event survives
	wire logic [W-1:0] next_event = ((clear ? {W{1'b0}} : event_q) | rise) & used;
	always_ff @(posedge clk) begin
		if (rst) begin
			cond_prev <= '0;
			event_q <= '0;
		end else begin
			cond_prev <= cond;
			event_q <= next_event;
		end
	end
endmodule : ser_event_latch

/* File: ser_status_top.sv */
`timescale 1ns/10ps
`include "ser_map.svh"
// What this block does
// - status query shows summary in bit six, poll shows request bit
// - query runs in order, never drops request
// - message-available holds until buffer empty
// - operation complete sets event bit zero
// - event summary is status bit five
// - enabled event bits feed group summaries
// - bit zero flags output voltage overload
// - bit four flags over temperature
// - bit five flags reference loop unlocked
// - bit seven flags modulation input overload
// - bit eight flags calibration problem
// - bit nine flags external timebase used
// - unused bits always read zero
// - questionable events cleared by clear, query
// - questionable mask cleared power-on, preset, zero
// - complete bit waits for all operations
// - bit two flags query error
// - bits three to five flag errors
// - bit seven flags power came up
// - standard events cleared by clear, query
// - event mask cleared per power-on setting
// - event bits latch until cleared
// - status byte holds four summary bits
// - rising summary raises request, poll clears
module ser_status_top (
	input wire logic CLK_SYS,
	input wire logic RST,
	input wire logic PWR_UP,
	input wire logic [15:0] QUES_COND,
	input wire ser_pkg::ser_cmd_t CMD,
	input wire ser_pkg::ser_err_t ERR,
	input wire logic [15:0] WR_DATA,
	input wire logic CMDS_DONE,
	input wire logic OVERLAP_BUSY,
	input wire logic MSG_PENDING,
	input wire logic ERRQ_NONEMPTY,
	input wire logic SERIAL_POLL,
	output logic SRQ,
	output logic [7:0] POLL_BYTE,
	output logic [7:0] STB_BYTE,
	output logic [15:0] QUES_COND_OUT,
	output logic [15:0] QUES_EVENT,
	output logic [15:0] QUES_ENABLE,
	output logic [7:0] ESR_EVENT,
	output logic [7:0] ESR_ENABLE,
	output logic [7:0] SRE_ENABLE,
	output logic PSC
);
	// ****************************************
	// pin synchronisers
	// ****************************************
	// condition pins are asynchronous to the sequencer
	logic [15:0] cond_s1;
	logic [15:0] cond_s2;
	logic [2:0] pin_s1;
	logic [2:0] pin_s2;
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			cond_s1 <= '0;
			cond_s2 <= '0;
			pin_s1 <= '0;
			pin_s2 <= '0;
		end else begin
			cond_s1 <= QUES_COND;
			cond_s2 <= cond_s1;
			pin_s1 <= {MSG_PENDING, ERRQ_NONEMPTY, SERIAL_POLL};
			pin_s2 <= pin_s1;
		end
	end
	wire logic mav = pin_s2[2];
	wire logic errq = pin_s2[1];
	wire logic poll = pin_s2[0];

	function automatic logic any_enabled16(input logic [15:0] e, input logic [15:0] m);
		any_enabled16 = |(e & m);
	endfunction : any_enabled16

	// ****************************************
	// questionable group
	// ****************************************
	wire logic [15:0] ques_used = `SER_QUES_USED;
	wire logic [15:0] ques_cond_m = cond_s2 & ques_used;
	wire logic ques_clear = CMD.clear_status | CMD.ques_query;
	ser_event_latch #(.W(16)) u_ques (
		.clk(CLK_SYS),
		.rst(RST),
		.cond(ques_cond_m),
		.pulse(`SER_ZERO16),
		.used(ques_used),
		.clear(ques_clear),
		.event_q(QUES_EVENT)
	);
	logic [15:0] ques_en;
	// mask never survives power-on, whatever the power-on-clear setting
	wire logic [15:0] next_ques_en = CMD.status_preset ? `SER_ZERO16 :
		(CMD.ques_en_write ? (WR_DATA & ques_used) : ques_en);
	always_ff @(posedge CLK_SYS) begin
		if (RST) ques_en <= `SER_ZERO16;
		else ques_en <= next_ques_en;
	end

	// ****************************************
	// operation complete sequencer
	// ****************************************
	ser_pkg::ser_opc_state_t opc_state;
	ser_pkg::ser_opc_state_t next_opc_state;
	wire logic opc_idle = (opc_state == ser_pkg::SER_OPC_IDLE);
	wire logic opc_fire = !opc_idle && CMDS_DONE && !OVERLAP_BUSY;
	always_comb begin
		next_opc_state = opc_state;
		unique case (opc_state)
			ser_pkg::SER_OPC_IDLE: if (CMD.opc_cmd) next_opc_state = ser_pkg::SER_OPC_WAIT;
			ser_pkg::SER_OPC_WAIT: begin
				// clear status cancels a pending completion
				if (CMD.clear_status || opc_fire) next_opc_state = ser_pkg::SER_OPC_IDLE;
			end
			default: next_opc_state = ser_pkg::SER_OPC_IDLE;
		endcase
	end
	always_ff @(posedge CLK_SYS) begin
		if (RST) opc_state <= ser_pkg::SER_OPC_IDLE;
		else opc_state <= next_opc_state;
	end

	// ****************************************
	// standard event group
	// ****************************************
	logic pwr_seen;
	always_ff @(posedge CLK_SYS) begin
		if (RST) pwr_seen <= 1'b0;
		else pwr_seen <= 1'b1;
	end
	wire logic pon_pulse = !pwr_seen && PWR_UP;
	wire logic [7:0] esr_pulse = {
		pon_pulse, 1'b0, ERR.cmd_error, ERR.exec_error,
		ERR.device_error, ERR.query_error, 1'b0, opc_fire && !CMD.clear_status
	};
	wire logic esr_clear = CMD.clear_status | CMD.esr_query;
	ser_event_latch #(.W(8)) u_esr (
		.clk(CLK_SYS),
		.rst(RST),
		.cond(`SER_ZERO8),
		.pulse(esr_pulse),
		.used(`SER_ESR_USED),
		.clear(esr_clear),
		.event_q(ESR_EVENT)
	);
	// power-on-clear setting and the event and request enables are nonvolatile in spirit:
	// reset only clears those enables when the setting says so
	logic psc;
	logic [7:0] esr_en;
	logic [7:0] sre_en;
	logic init_done;
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			init_done <= 1'b0;
		end else begin
			init_done <= 1'b1;
		end
	end
	always_ff @(posedge CLK_SYS) begin
		if (!init_done && !RST && psc) begin
			esr_en <= `SER_ZERO8;
			sre_en <= `SER_ZERO8;
		end else if (!RST) begin
			if (CMD.esr_en_write) esr_en <= WR_DATA[7:0] & `SER_ESR_USED;
			if (CMD.sre_write) sre_en <= WR_DATA[7:0] & `SER_STB_USED;
		end
	end
	always_ff @(posedge CLK_SYS) begin
		if (CMD.psc_write && !RST) psc <= WR_DATA[0];
		else if (psc !== 1'b0 && psc !== 1'b1) psc <= `SER_PSC_DEFAULT;
	end

	// ****************************************
	// status byte and service request
	// ****************************************
	wire logic ques_sum = any_enabled16(QUES_EVENT, ques_en);
	wire logic esr_sum = any_enabled16({8'h00, ESR_EVENT}, {8'h00, esr_en});
	wire logic [7:0] stb_low = {2'b00, esr_sum, mav, ques_sum, errq, 2'b00};
	wire logic mss = |(stb_low & sre_en);
	logic mss_prev;
	logic request_service_bit;
	// poll clears only the request bit; the query never touches it
	wire logic next_rqs = (mss && !mss_prev) ? 1'b1 : (poll ? 1'b0 : request_service_bit);
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			mss_prev <= 1'b0;
			request_service_bit <= 1'b0;
			STB_BYTE <= `SER_ZERO8;
			POLL_BYTE <= `SER_ZERO8;
		end else begin
			mss_prev <= mss;
			request_service_bit <= next_rqs;
			// query byte captured when the command executes, in order
			if (CMD.stb_query) STB_BYTE <= stb_low | {1'b0, mss, 6'h00};
			POLL_BYTE <= stb_low | {1'b0, next_rqs, 6'h00};
		end
	end
	assign SRQ = request_service_bit;
	assign QUES_COND_OUT = ques_cond_m;
	assign QUES_ENABLE = ques_en;
	assign ESR_ENABLE = esr_en;
	assign SRE_ENABLE = sre_en;
	assign PSC = psc;

	// ****************************************
	// checks
	// ****************************************
	a_ques_unused_zero: assert property (@(posedge CLK_SYS) disable iff (RST)
		(QUES_EVENT & ~`SER_QUES_USED) == 16'h0000) else $error("unused questionable bit set");
	a_esr_unused_zero: assert property (@(posedge CLK_SYS) disable iff (RST)
		(ESR_EVENT & ~`SER_ESR_USED) == 8'h00) else $error("unused event bit set");
	a_ques_query_clear: assert property (@(posedge CLK_SYS) disable iff (RST)
		CMD.ques_query && $stable(cond_s2) && cond_s2 == $past(cond_s2) |=> QUES_EVENT == 16'h0000)
		else $error("questionable not cleared");
	a_esr_event_hold: assert property (@(posedge CLK_SYS) disable iff (RST)
		ESR_EVENT[`SER_ESR_CME] && !esr_clear |=> ESR_EVENT[`SER_ESR_CME])
		else $error("event bit lost");
	a_opc_bit_wait: assert property (@(posedge CLK_SYS) disable iff (RST)
		$rose(ESR_EVENT[`SER_ESR_OPC]) |-> $past(CMDS_DONE) && !$past(OVERLAP_BUSY))
		else $error("complete set early");
	a_srq_rise_mss: assert property (@(posedge CLK_SYS) disable iff (RST)
		mss && !mss_prev |=> SRQ && POLL_BYTE[`SER_STB_RQS]) else $error("request not raised");
	a_srq_poll_clear: assert property (@(posedge CLK_SYS) disable iff (RST)
		poll && !(mss && !mss_prev) |=> !SRQ) else $error("poll did not clear request");
	a_stb_query_mss: assert property (@(posedge CLK_SYS) disable iff (RST)
		CMD.stb_query |=> STB_BYTE[`SER_STB_RQS] == $past(mss)) else $error("query summary wrong");
	a_query_keeps_srq: assert property (@(posedge CLK_SYS) disable iff (RST)
		SRQ && CMD.stb_query && !poll |=> SRQ) else $error("query dropped request");
	a_ques_en_preset: assert property (@(posedge CLK_SYS) disable iff (RST)
		CMD.status_preset |=> QUES_ENABLE == 16'h0000) else $error("preset left mask");
	a_esb_summary: assert property (@(posedge CLK_SYS) disable iff (RST)
		CMD.stb_query |=> STB_BYTE[`SER_STB_ESB] == $past(esr_sum))
		else $error("event summary wrong");
	a_stb_unused_zero: assert property (@(posedge CLK_SYS) disable iff (RST)
		(STB_BYTE & ~(`SER_STB_USED | 8'h40)) == 8'h00) else $error("unused status bit set");
	a_stb_query_mav: assert property (@(posedge CLK_SYS) disable iff (RST)
		CMD.stb_query |=> STB_BYTE[`SER_STB_MAV] == $past(mav)) else $error("message bit wrong");
	a_query_error_set: assert property (@(posedge CLK_SYS) disable iff (RST)
		ERR.query_error |=> ESR_EVENT[`SER_ESR_QYE]) else $error("query error not latched");
endmodule : ser_status_top

/* File: ser_host_model.sv */
`timescale 1ns/10ps
module ser_host_model (
	input wire logic clk,
	input wire logic req,
	input wire logic [7:0] poll_byte,
	output logic serial_poll,
	output logic [7:0] resp,
	output logic done
);
	// ****************************************
	// host side serial poll
	// ****************************************
	// poll held two cycles: a one-cycle pulse is legal but leaves no margin
	initial begin
		serial_poll = 1'b0;
		resp = 8'h00;
		done = 1'b0;
		forever begin
			@(posedge clk);
			if (req) begin
				done <= 1'b0;
				serial_poll <= 1'b1;
				resp <= poll_byte;
				repeat (2) @(posedge clk);
				serial_poll <= 1'b0;
				done <= 1'b1;
			end
		end
	end
endmodule : ser_host_model

/* File: tb.sv */
`timescale 1ns/10ps
module tb;
	// ****************************************
	// stimulus and counters
	// ****************************************
	localparam logic [9:0] C_CLS = 10'h200;
	localparam logic [9:0] C_PRE = 10'h100;
	localparam logic [9:0] C_QQ = 10'h080;
	localparam logic [9:0] C_EQ = 10'h040;
	localparam logic [9:0] C_STB = 10'h020;
	localparam logic [9:0] C_QEN = 10'h010;
	localparam logic [9:0] C_EEN = 10'h008;
	localparam logic [9:0] C_SRE = 10'h004;
	localparam logic [9:0] C_PSC = 10'h002;
	localparam logic [9:0] C_OPC = 10'h001;
	logic clk, rst, pwr_up, done_in, busy_in, msg, errq, poll, srq, psc, preq, pdone;
	logic [15:0] cond, wdata, cond_out, qev, qen;
	ser_pkg::ser_cmd_t cmd;
	ser_pkg::ser_err_t err;
	logic [7:0] pbyte, stb, eev, een, sre, presp;
	logic [15:0] qbits [6] = '{16'h0001, 16'h0010, 16'h0020, 16'h0080, 16'h0100, 16'h0200};
	int err_total = 0;
	int n_tests = 0;
	ser_status_top u_ser_status_top (.CLK_SYS(clk), .RST(rst), .PWR_UP(pwr_up),
		.QUES_COND(cond), .CMD(cmd), .ERR(err), .WR_DATA(wdata), .CMDS_DONE(done_in),
		.OVERLAP_BUSY(busy_in), .MSG_PENDING(msg), .ERRQ_NONEMPTY(errq),
		.SERIAL_POLL(poll), .SRQ(srq), .POLL_BYTE(pbyte), .STB_BYTE(stb),
		.QUES_COND_OUT(cond_out), .QUES_EVENT(qev), .QUES_ENABLE(qen),
		.ESR_EVENT(eev), .ESR_ENABLE(een), .SRE_ENABLE(sre), .PSC(psc));
	ser_host_model u_ser_host_model (.clk(clk), .req(preq), .poll_byte(pbyte),
		.serial_poll(poll), .resp(presp), .done(pdone));
	// ****************************************
	// shared tasks
	// ****************************************
	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick
	task automatic issue(input logic [9:0] c, input logic [15:0] d);
		cmd <= ser_pkg::ser_cmd_t'(c);
		wdata <= d;
		tick(1);
		cmd <= ser_pkg::ser_cmd_t'(10'h000);
		tick(4);
	endtask : issue
	task automatic do_reset;
		rst <= 1'b1;
		tick(12);
		rst <= 1'b0;
		tick(3);
	endtask : do_reset
	task automatic host_poll;
		int i;
		preq <= 1'b1;
		tick(1);
		preq <= 1'b0;
		tick(1);
		for (i = 0; i < 50 && pdone !== 1'b1; i++) tick(1);
		if (pdone !== 1'b1) begin
			err_total++;
			results();
		end
		tick(6);
	endtask : host_poll
	task automatic err_pulse(input logic [3:0] v);
		err <= ser_pkg::ser_err_t'(v);
		tick(1);
		err <= ser_pkg::ser_err_t'(4'h0);
		tick(6);
	endtask : err_pulse
	task automatic results;
		$display("comparisons %0d errors %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : results
	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_power;
		chk("esr_event", 16'h0080, {8'h00, eev});
		chk("ques_enable", 16'h0000, qen);
		issue(C_EQ, 16'h0000);
		chk("esr_event", 16'h0000, {8'h00, eev});
	endtask : t_power
	task automatic t_ques;
		foreach (qbits[k]) begin
			cond <= qbits[k];
			tick(6);
			chk("ques_event", qbits[k], qev);
			issue(C_QQ, 16'h0000);
			chk("ques_event", 16'h0000, qev);
			cond <= 16'h0000;
			tick(4);
		end
		cond <= 16'hFFFF;
		tick(6);
		chk("ques_cond", 16'h03B1, cond_out);
		chk("ques_event", 16'h03B1, qev);
		issue(C_CLS, 16'h0000);
		chk("ques_event", 16'h0000, qev);
		issue(C_QEN, 16'h0001);
		issue(C_SRE, 16'h0008);
		cond <= 16'h0000;
		tick(4);
		cond <= 16'h0011;
		tick(6);
		issue(C_STB, 16'h0000);
		chk("stb_byte", 16'h0048, {8'h00, stb});
		issue(C_QEN, 16'h0002);
		issue(C_STB, 16'h0000);
		chk("stb_byte", 16'h0000, {8'h00, stb});
		cond <= 16'h0000;
		issue(C_CLS, 16'h0000);
	endtask : t_ques
	task automatic t_srq;
		issue(C_CLS, 16'h0000);
		issue(C_EEN, 16'h0020);
		issue(C_SRE, 16'h0020);
		host_poll();
		chk("srq", 16'h0000, {15'h0000, srq});
		err_pulse(4'h8);
		chk("esr_event", 16'h0004, {8'h00, eev});
		chk("srq", 16'h0000, {15'h0000, srq});
		err_pulse(4'h4);
		chk("esr_event", 16'h000C, {8'h00, eev});
		err_pulse(4'h2);
		chk("esr_event", 16'h001C, {8'h00, eev});
		chk("srq", 16'h0000, {15'h0000, srq});
		err_pulse(4'h1);
		chk("esr_event", 16'h003C, {8'h00, eev});
		chk("srq", 16'h0001, {15'h0000, srq});
		host_poll();
		chk("poll_resp", 16'h0060, {8'h00, presp});
		chk("poll_byte", 16'h0020, {8'h00, pbyte});
		chk("srq", 16'h0000, {15'h0000, srq});
		issue(C_STB, 16'h0000);
		chk("stb_byte", 16'h0060, {8'h00, stb});
		chk("srq", 16'h0000, {15'h0000, srq});
		issue(C_CLS, 16'h0000);
		issue(C_STB, 16'h0000);
		chk("stb_byte", 16'h0000, {8'h00, stb});
	endtask : t_srq
	task automatic t_mav_opc;
		msg <= 1'b1;
		errq <= 1'b1;
		tick(5);
		issue(C_STB, 16'h0000);
		chk("stb_byte", 16'h0014, {8'h00, stb});
		msg <= 1'b0;
		errq <= 1'b0;
		tick(5);
		issue(C_STB, 16'h0000);
		chk("stb_byte", 16'h0000, {8'h00, stb});
		done_in <= 1'b0;
		issue(C_OPC, 16'h0000);
		chk("esr_event", 16'h0000, {8'h00, eev});
		done_in <= 1'b1;
		busy_in <= 1'b1;
		tick(4);
		chk("esr_event", 16'h0000, {8'h00, eev});
		busy_in <= 1'b0;
		tick(4);
		chk("esr_event", 16'h0001, {8'h00, eev});
		issue(C_EQ, 16'h0000);
	endtask : t_mav_opc
	task automatic t_enables;
		issue(C_QEN, 16'hFFFF);
		chk("ques_enable", 16'h03B1, qen);
		issue(C_PRE, 16'h0000);
		chk("ques_enable", 16'h0000, qen);
		issue(C_QEN, 16'h0010);
		issue(C_QEN, 16'h0000);
		chk("ques_enable", 16'h0000, qen);
		issue(C_EEN, 16'h00FF);
		chk("esr_enable", 16'h00BD, {8'h00, een});
		issue(C_EEN, 16'h0000);
		chk("esr_enable", 16'h0000, {8'h00, een});
		issue(C_EEN, 16'h0021);
		issue(C_QEN, 16'h0010);
		issue(C_PSC, 16'h0000);
		chk("psc", 16'h0000, {15'h0000, psc});
		do_reset();
		chk("esr_enable", 16'h0021, {8'h00, een});
		chk("sre_enable", 16'h0020, {8'h00, sre});
		chk("ques_enable", 16'h0000, qen);
		issue(C_PSC, 16'h0001);
		chk("psc", 16'h0001, {15'h0000, psc});
		do_reset();
		chk("esr_enable", 16'h0000, {8'h00, een});
		chk("sre_enable", 16'h0000, {8'h00, sre});
	endtask : t_enables
	// ****************************************
	// run control
	// ****************************************
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	initial begin
		rst = 1'b1;
		pwr_up = 1'b1;
		done_in = 1'b1;
		busy_in = 1'b0;
		msg = 1'b0;
		errq = 1'b0;
		preq = 1'b0;
		cond = 16'h0000;
		wdata = 16'h0000;
		cmd = ser_pkg::ser_cmd_t'(10'h000);
		err = ser_pkg::ser_err_t'(4'h0);
		do_reset();
		t_power();
		t_ques();
		t_srq();
		t_mav_opc();
		t_enables();
		results();
	end
	initial begin
		tick(20000);
		err_total++;
		results();
	end
endmodule : tb
